/* dod_cond_eval.v */
// Condition evaluator for conditional jumps and calls
`timescale 1ns/10ps
`include "dod_regs.vh"

module dod_cond_eval
(
    input  wire [1:0] cond_selector_i,
    input  wire [3:0] cond_state_i,
    input  wire [3:0] cond_mask_i,
    input  wire       accum_zero_i,
    input  wire       accum_neg_i,
    input  wire       overflow_i,
    input  wire       carry_i,
    input  wire       test_flag_i,
    input  wire       ext_low_i,
    output wire       met_o
);

    wire [3:0] flags;
    reg        cs_ok;
    wire       field_ok;

    assign flags = {accum_zero_i, accum_neg_i, overflow_i, carry_i};

    // Masked bits must match the required states
    assign field_ok = (((flags ~^ cond_state_i) & cond_mask_i) == cond_mask_i);

    always @*
    begin
        case (cond_selector_i)
            `DOD_CS_EXT_LOW:  cs_ok = ext_low_i;
            `DOD_CS_TEST_SET: cs_ok = test_flag_i;
            `DOD_CS_TEST_CLR: cs_ok = ~test_flag_i;
            default:          cs_ok = 1'b1;
        endcase
    end

    assign met_o = cs_ok & field_ok;

endmodule

/* dod_decoder.v */
// Opcode decoder for the first part of the instruction set
// What this block does
// - 0xbe00 decodes as accumulator magnitude, one word, one cycle.
// - Top nibble 0010 is shifted add; shift nibble, operand byte; 1/1.
// - Upper byte 0x61 sum_unsigned_op data word into high accumulator; 1/1.
// - Upper byte 0xb8 sum_unsigned_op low-byte constant to accumulator; 1/1.
// - 0xbf9 plus shift sum_unsigned_op shifted 16-bit second word; 2/2.
// - Upper bytes 0x60, 0x62, 0x63: carry, unsigned, temp-shift sum_unsigned_op; 1/1.
// - Upper byte 0x78 sum_unsigned_op byte constant to current aux register; 1 cycle.
// - Conjunction: 0x6e memory 1/1; 0xbfb shifted and 0xbe81 constants 2/2.
// - 0xbe04 sum_unsigned_op product register to accumulator; 1/1.
// - 0xbe20 jumps via accumulator 1/4; 0x79 jumps to second word 2/4.
// - 0x79 sibling 0x7b branches if aux nonzero; 2 words, 4 or 2.
// - 1110 00 plus selector, condition nibbles, target word: conditional jump.
// - 0xe000 jump on external status low: 4 taken, 3 not.
// - 0100 bit-select or 0x6f temp-chosen bit test into test flag.
// - 0xa8/0xa9 block copies; flag moves touching interrupt or global regs.
// - 0xa5 copies program memory block into data; 2 words, 3 cycles.
// - 0xbe30 calls via accumulator 4 cycles; 0x7a direct call 2/4.
// - 0xbe4x status resets with the seven listed low nibbles; 1 cycle.
// - 0xbe01 complements; 0xbf44-0xbf47 compares aux with aux zero; 1 cycle.
// - 0x77 copies word to next address; 0xbe22 idles until interrupt.
// - 0xaf port input with operand and port address word; 2/2.
// - Top nibble 0001 shifted load; 0xbf8 plus shift long load.
// - 0x6a clears low and loads high accumulator; 1/1.
// - Selector 00 ext low, 01 test set, 10 test clear, 11 none.
// - Low nibble masks flags, next nibble gives states; masked match decides.
`timescale 1ns/10ps
`include "dod_regs.vh"

module dod_decoder
#(
    parameter [15:0] IRQ_MASK_ADDR   = 16'h0001,
    parameter [15:0] IRQ_FLAG_ADDR   = 16'h0002,
    parameter [15:0] GLOBAL_MEM_ADDR = 16'h0003
)
(
    input  wire        clock_i,
    input  wire        sys_rst_i,

    input  wire        fetch_valid_i,
    input  wire [15:0] fetch_word_i,

    input  wire        accum_zero_i,
    input  wire        accum_neg_i,
    input  wire        overflow_i,
    input  wire        carry_i,
    input  wire        test_flag_i,
    input  wire        aux_nonzero_i,
    input  wire        ext_status_input_i,

    output wire        second_pending_o,
    output reg         dec_valid_o,
    output reg  [5:0]  op_class_o,
    output reg  [1:0]  words_o,
    output reg  [2:0]  cycles_o,
    output reg  [3:0]  shift_count_field_o,
    output reg  [7:0]  operand_byte_o,
    output reg         operand_is_addr_o,
    output reg  [15:0] long_word_o,
    output reg         branch_taken_o,
    output reg  [1:0]  cond_selector_o,
    output reg  [3:0]  low_nibble_o,
    output reg         mmr_hazard_o,
    output reg         unknown_o
);

    // ***************************************************************
    // States
    // ***************************************************************
    localparam [0:0] ST_FIRST  = 1'b0;
    localparam [0:0] ST_SECOND = 1'b1;

    // ***************************************************************
    // Decode functions
    // ***************************************************************
    // Returns {needs second word, class}
    function [6:0] dod_decode;
        input [15:0] w;
        begin
            casez (w)
                16'b1011_1110_0000_0000: dod_decode = {1'b0, `DOD_OP_MAGNITUDE};
                16'b0010_????_????_????: dod_decode = {1'b0, `DOD_OP_SUM_SHIFT};
                16'b0110_0001_????_????: dod_decode = {1'b0, `DOD_OP_SUM_HIGH};
                16'b1011_1000_????_????: dod_decode = {1'b0, `DOD_OP_SUM_SHORT};
                16'b1011_1111_1001_????: dod_decode = {1'b1, `DOD_OP_SUM_LONG};

                16'b0110_0000_????_????: dod_decode = {1'b0, `DOD_OP_SUM_CARRY};
                16'b0110_0010_????_????: dod_decode = {1'b0, `DOD_OP_SUM_UNSIGNED};
                16'b0110_0011_????_????: dod_decode = {1'b0, `DOD_OP_SUM_TSHIFT};
                16'b0111_1000_????_????: dod_decode = {1'b0, `DOD_OP_AUX_INC};

                16'b0110_1110_????_????: dod_decode = {1'b0, `DOD_OP_AND_MEM};
                16'b1011_1111_1011_????: dod_decode = {1'b1, `DOD_OP_AND_LONG};
                16'b1011_1110_1000_0001: dod_decode = {1'b1, `DOD_OP_AND_HI16};
                16'b1011_1110_0000_0100: dod_decode = {1'b0, `DOD_OP_PROD_ACC};

                16'b1011_1110_0010_0000: dod_decode = {1'b0, `DOD_OP_JUMP_ACC};
                16'b0111_1001_????_????: dod_decode = {1'b1, `DOD_OP_JUMP};
                16'b0111_1011_????_????: dod_decode = {1'b1, `DOD_OP_LOOP_AUX};

                16'b1110_00??_????_????: dod_decode = {1'b1, `DOD_OP_COND_JUMP};
                16'b1110_10??_????_????: dod_decode = {1'b1, `DOD_OP_COND_CALL};

                16'b0100_????_????_????: dod_decode = {1'b0, `DOD_OP_BIT_TEST};
                16'b0110_1111_????_????: dod_decode = {1'b0, `DOD_OP_BIT_TEMP};
                16'b1010_1000_????_????: dod_decode = {1'b1, `DOD_OP_BLK_SRC};
                16'b1010_1001_????_????: dod_decode = {1'b1, `DOD_OP_BLK_DST};
                16'b1010_0101_????_????: dod_decode = {1'b1, `DOD_OP_PROG_DATA};

                16'b1011_1110_0011_0000: dod_decode = {1'b0, `DOD_OP_CALL_ACC};
                16'b0111_1010_????_????: dod_decode = {1'b1, `DOD_OP_CALL};

                16'b1011_1110_0100_0100,
                16'b1011_1110_0100_0000,
                16'b1011_1110_0100_1110,
                16'b1011_1110_0100_0010,
                16'b1011_1110_0100_0110,
                16'b1011_1110_0100_1010,
                16'b1011_1110_0100_1100: dod_decode = {1'b0, `DOD_OP_STATUS_RESET};

                16'b1011_1110_0000_0001: dod_decode = {1'b0, `DOD_OP_COMPLEMENT};
                16'b1011_1111_0100_01??: dod_decode = {1'b0, `DOD_OP_AUX_CMP};
                16'b0111_0111_????_????: dod_decode = {1'b0, `DOD_OP_DATA_SHIFT};
                16'b1011_1110_0010_0010: dod_decode = {1'b0, `DOD_OP_IDLE};

                16'b1010_1111_????_????: dod_decode = {1'b1, `DOD_OP_PORT_IN};
                16'b0001_????_????_????: dod_decode = {1'b0, `DOD_OP_LOAD_SHIFT};
                16'b1011_1111_1000_????: dod_decode = {1'b1, `DOD_OP_LOAD_LONG};
                16'b0110_1010_????_????: dod_decode = {1'b0, `DOD_OP_LOAD_HIGH};
                default:                 dod_decode = {1'b0, `DOD_OP_UNKNOWN};
            endcase
        end
    endfunction

    // Classes whose low byte is a direct or indirect data address
    function dod_is_addr;
        input [5:0] cls;
        begin
            case (cls)
                `DOD_OP_SUM_SHIFT, `DOD_OP_SUM_HIGH, `DOD_OP_SUM_CARRY,
                `DOD_OP_SUM_UNSIGNED, `DOD_OP_SUM_TSHIFT, `DOD_OP_AND_MEM,
                `DOD_OP_JUMP, `DOD_OP_LOOP_AUX, `DOD_OP_BIT_TEST, `DOD_OP_BIT_TEMP,
                `DOD_OP_BLK_SRC, `DOD_OP_BLK_DST, `DOD_OP_PROG_DATA, `DOD_OP_CALL,
                `DOD_OP_DATA_SHIFT, `DOD_OP_PORT_IN, `DOD_OP_LOAD_SHIFT,
                `DOD_OP_LOAD_HIGH: dod_is_addr = 1'b1;
                default:           dod_is_addr = 1'b0;
            endcase
        end
    endfunction

    // Cycle count; branch outcome changes it for the conditional forms
    function [2:0] dod_cycles;
        input [5:0] cls;
        input       taken;
        input [1:0] cs;
        begin
            case (cls)
                `DOD_OP_JUMP_ACC, `DOD_OP_JUMP,
                `DOD_OP_CALL_ACC, `DOD_OP_CALL:  dod_cycles = `DOD_CYC_FOUR;

                `DOD_OP_LOOP_AUX, `DOD_OP_COND_CALL:
                    dod_cycles = taken ? `DOD_CYC_FOUR : `DOD_CYC_TWO;

                `DOD_OP_COND_JUMP:
                    if (taken)
                        dod_cycles = `DOD_CYC_FOUR;
                    else if (cs == `DOD_CS_EXT_LOW)
                        dod_cycles = `DOD_CYC_THREE;
                    else
                        dod_cycles = `DOD_CYC_TWO;

                `DOD_OP_BLK_SRC, `DOD_OP_BLK_DST,
                `DOD_OP_PROG_DATA:               dod_cycles = `DOD_CYC_THREE;

                `DOD_OP_SUM_LONG, `DOD_OP_AND_LONG, `DOD_OP_AND_HI16,
                `DOD_OP_PORT_IN, `DOD_OP_LOAD_LONG: dod_cycles = `DOD_CYC_TWO;

                default:                         dod_cycles = `DOD_CYC_ONE;
            endcase
        end
    endfunction

    // ***************************************************************
    // External status pin synchroniser
    // ***************************************************************
    reg ext_meta_q;
    reg ext_sync_q;

    always @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ext_meta_q <= 1'b1;
            ext_sync_q <= 1'b1;
        end
        else
        begin
            ext_meta_q <= ext_status_input_i;
            ext_sync_q <= ext_meta_q;
        end
    end

    // ***************************************************************
    // First-word holding and state
    // ***************************************************************
    reg         state_q;
    reg [15:0]  first_q;
    wire [6:0]  dec_now;
    wire [6:0]  dec_held;
    wire [5:0]  cls_held;
    wire        cond_met;
    reg         taken_d;

    assign dec_now          = dod_decode(fetch_word_i);
    assign dec_held         = dod_decode(first_q);
    assign cls_held         = dec_held[5:0];
    assign second_pending_o = (state_q == ST_SECOND);

    dod_cond_eval u_cond
    (
        .cond_selector_i (first_q[`DOD_CS_MSB:`DOD_CS_LSB]),
        .cond_state_i    (first_q[`DOD_STATE_MSB:`DOD_STATE_LSB]),
        .cond_mask_i     (first_q[`DOD_LOWNIB_MSB:`DOD_LOWNIB_LSB]),
        .accum_zero_i    (accum_zero_i),
        .accum_neg_i     (accum_neg_i),
        .overflow_i      (overflow_i),
        .carry_i         (carry_i),
        .test_flag_i     (test_flag_i),
        .ext_low_i       (~ext_sync_q),
        .met_o           (cond_met)
    );

    always @*
    begin
        case (cls_held)
            `DOD_OP_JUMP, `DOD_OP_CALL:            taken_d = 1'b1;
            `DOD_OP_LOOP_AUX:                      taken_d = aux_nonzero_i;
            `DOD_OP_COND_JUMP, `DOD_OP_COND_CALL:  taken_d = cond_met;
            default:                               taken_d = 1'b0;
        endcase
    end

    // ***************************************************************
    // Sequencing and output registers
    // ***************************************************************
    // Second word is taken on the next valid fetch; no stall is needed
    // because the decoder accepts one word per cycle.
    always @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_q             <= ST_FIRST;
            first_q             <= `DOD_RST_WORD;

            dec_valid_o         <= 1'b0;
            op_class_o          <= `DOD_OP_UNKNOWN;
            words_o             <= `DOD_WORDS_ONE;
            cycles_o            <= `DOD_CYC_ONE;
            shift_count_field_o <= `DOD_RST_NIB;
            operand_byte_o      <= `DOD_RST_BYTE;
            operand_is_addr_o   <= 1'b0;
            long_word_o         <= `DOD_RST_WORD;
            branch_taken_o      <= 1'b0;
            cond_selector_o     <= `DOD_CS_NONE;
            low_nibble_o        <= `DOD_RST_NIB;
            mmr_hazard_o        <= 1'b0;
            unknown_o           <= 1'b0;
        end
        else
        begin
            dec_valid_o <= 1'b0;

            case (state_q)
                ST_FIRST:
                begin
                    if (fetch_valid_i)
                    begin
                        first_q <= fetch_word_i;

                        if (dec_now[6])
                        begin
                            state_q <= ST_SECOND;
                        end
                        else
                        begin
                            dec_valid_o         <= 1'b1;
                            op_class_o          <= dec_now[5:0];
                            words_o             <= `DOD_WORDS_ONE;
                            cycles_o            <= dod_cycles(dec_now[5:0], 1'b0, `DOD_CS_NONE);
                            shift_count_field_o <= fetch_word_i[`DOD_SHIFT_MSB:`DOD_SHIFT_LSB];
                            operand_byte_o      <= fetch_word_i[`DOD_BYTE_MSB:`DOD_BYTE_LSB];
                            operand_is_addr_o   <= dod_is_addr(dec_now[5:0]);
                            long_word_o         <= `DOD_RST_WORD;
                            branch_taken_o      <= (dec_now[5:0] == `DOD_OP_JUMP_ACC) ||
                                                   (dec_now[5:0] == `DOD_OP_CALL_ACC);
                            cond_selector_o     <= `DOD_CS_NONE;
                            low_nibble_o        <= fetch_word_i[`DOD_LOWNIB_MSB:`DOD_LOWNIB_LSB];
                            mmr_hazard_o        <= 1'b0;
                            unknown_o           <= (dec_now[5:0] == `DOD_OP_UNKNOWN);
                        end
                    end
                end

                ST_SECOND:
                begin
                    if (fetch_valid_i)
                    begin
                        state_q             <= ST_FIRST;
                        dec_valid_o         <= 1'b1;
                        op_class_o          <= cls_held;
                        words_o             <= `DOD_WORDS_TWO;
                        cycles_o            <= dod_cycles(cls_held, taken_d,
                                                   first_q[`DOD_CS_MSB:`DOD_CS_LSB]);
                        shift_count_field_o <= first_q[`DOD_LOWNIB_MSB:`DOD_LOWNIB_LSB];
                        operand_byte_o      <= first_q[`DOD_BYTE_MSB:`DOD_BYTE_LSB];
                        operand_is_addr_o   <= dod_is_addr(cls_held);
                        long_word_o         <= fetch_word_i;
                        branch_taken_o      <= taken_d;
                        cond_selector_o     <= first_q[`DOD_CS_MSB:`DOD_CS_LSB];
                        low_nibble_o        <= first_q[`DOD_LOWNIB_MSB:`DOD_LOWNIB_LSB];

                        // Only the immediate address word is checked here
                        mmr_hazard_o        <= ((cls_held == `DOD_OP_BLK_SRC) ||
                                                (cls_held == `DOD_OP_BLK_DST)) &&
                                               ((fetch_word_i == IRQ_MASK_ADDR) ||
                                                (fetch_word_i == IRQ_FLAG_ADDR) ||
                                                (fetch_word_i == GLOBAL_MEM_ADDR));
                        unknown_o           <= 1'b0;
                    end
                end

                default:
                begin
                    state_q <= ST_FIRST;
                end
            endcase
        end
    end

endmodule

/* dod_decoder_properties.sv */
// Concurrent checks on the opcode decoder ports
`timescale 1ns/10ps
module dod_decoder_properties
(
    input wire        clock_i,
    input wire        sys_rst_i,
    input wire        fetch_valid_i,
    input wire [15:0] fetch_word_i,
    input wire        second_pending_o,
    input wire        dec_valid_o,
    input wire [5:0]  op_class_o,
    input wire [1:0]  words_o,
    input wire [2:0]  cycles_o,
    input wire [3:0]  shift_count_field_o,
    input wire [7:0]  operand_byte_o,
    input wire [15:0] long_word_o,
    input wire        branch_taken_o,
    input wire [1:0]  cond_selector_o
);
    // ***************************************************************
    // Decode relations
    // ***************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sequence first_w;
        fetch_valid_i && !second_pending_o;
    endsequence
    sequence second_w;
        fetch_valid_i && second_pending_o;
    endsequence
    mag_decode_a: assert property (first_w ##0 fetch_word_i == 16'hbe00 |=>
        dec_valid_o && op_class_o == 6'h01 && words_o == 2'h1 && cycles_o == 3'h1)
        else $error("magnitude decode wrong");
    shift_add_a: assert property (first_w ##0 fetch_word_i[15:12] == 4'h2 |=>
        op_class_o == 6'h02 && shift_count_field_o == $past(fetch_word_i[11:8]))
        else $error("shifted add decode wrong");
    operand_pass_a: assert property (first_w ##1 dec_valid_o |->
        operand_byte_o == $past(fetch_word_i[7:0])) else $error("operand byte altered");
    jump_wait_a: assert property (first_w ##0 fetch_word_i[15:8] == 8'h79 |=>
        second_pending_o && !dec_valid_o) else $error("jump did not wait for target");
    pair_done_a: assert property (second_w |=>
        dec_valid_o && words_o == 2'h2 && !second_pending_o) else $error("pair not closed");
    long_word_a: assert property (second_w |=>
        long_word_o == $past(fetch_word_i)) else $error("second word not passed");
    status_rst_a: assert property (first_w ##0 fetch_word_i == 16'hbe4e |=>
        op_class_o == 6'h1a) else $error("status reset decode wrong");
    aux_cmp_a: assert property (first_w ##0 fetch_word_i[15:2] == 14'h2fd1 |=>
        op_class_o == 6'h1c) else $error("aux compare decode wrong");
    loop_cyc_a: assert property (dec_valid_o && op_class_o == 6'h10 |->
        cycles_o == (branch_taken_o ? 3'h4 : 3'h2)) else $error("loop branch cycles wrong");
    io_cyc_a: assert property (dec_valid_o && op_class_o == 6'h11 && cond_selector_o == 2'h0
        |-> cycles_o == (branch_taken_o ? 3'h4 : 3'h3)) else $error("status branch cycles wrong");
endmodule

/* dod_fetch.sv */
// Fetch-side model handing program words to the decoder
`timescale 1ns/10ps
module dod_fetch
(
    input  wire         clock_i,
    output logic        fetch_valid_o,
    output logic [15:0] fetch_word_o
);
    // ***************************************************************
    // Word delivery
    // ***************************************************************
    initial
    begin
        fetch_valid_o = 1'b0;
        fetch_word_o  = 16'h0000;
    end
    task automatic put(input logic [15:0] w);
        fetch_valid_o = 1'b1;
        fetch_word_o  = w;
        @(posedge clock_i);
        #1;
    endtask
    task automatic gap(input int n);
        fetch_valid_o = 1'b0;
        fetch_word_o  = ~fetch_word_o; // Idle bus never repeats the last word
        repeat (n) @(posedge clock_i);
        #1;
    endtask
endmodule

/* dod_regs.vh */
// Constants for the opcode decoder: operation classes, field positions, cycle counts
`ifndef DOD_REGS_VH
`define DOD_REGS_VH

// ***************************************************************
// Operation class codes
// ***************************************************************
`define DOD_OP_UNKNOWN      6'h00
`define DOD_OP_MAGNITUDE    6'h01
`define DOD_OP_SUM_SHIFT    6'h02
`define DOD_OP_SUM_HIGH     6'h03
`define DOD_OP_SUM_SHORT    6'h04
`define DOD_OP_SUM_LONG     6'h05
`define DOD_OP_SUM_CARRY    6'h06
`define DOD_OP_SUM_UNSIGNED 6'h07
`define DOD_OP_SUM_TSHIFT   6'h08
`define DOD_OP_AUX_INC      6'h09
`define DOD_OP_AND_MEM      6'h0a
`define DOD_OP_AND_LONG     6'h0b
`define DOD_OP_AND_HI16     6'h0c
`define DOD_OP_PROD_ACC     6'h0d
`define DOD_OP_JUMP_ACC     6'h0e
`define DOD_OP_JUMP         6'h0f
`define DOD_OP_LOOP_AUX     6'h10
`define DOD_OP_COND_JUMP    6'h11
`define DOD_OP_COND_CALL    6'h12
`define DOD_OP_BIT_TEST     6'h13
`define DOD_OP_BIT_TEMP     6'h14
`define DOD_OP_BLK_SRC      6'h15
`define DOD_OP_BLK_DST      6'h16
`define DOD_OP_PROG_DATA    6'h17
`define DOD_OP_CALL_ACC     6'h18
`define DOD_OP_CALL         6'h19
`define DOD_OP_STATUS_RESET 6'h1a
`define DOD_OP_COMPLEMENT   6'h1b
`define DOD_OP_AUX_CMP      6'h1c
`define DOD_OP_DATA_SHIFT   6'h1d
`define DOD_OP_IDLE         6'h1e
`define DOD_OP_PORT_IN      6'h1f
`define DOD_OP_LOAD_SHIFT   6'h20
`define DOD_OP_LOAD_LONG    6'h21
`define DOD_OP_LOAD_HIGH    6'h22

// ***************************************************************
// Field positions in the first word
// ***************************************************************
`define DOD_SHIFT_MSB       11
`define DOD_SHIFT_LSB       8
`define DOD_LOWNIB_MSB      3
`define DOD_LOWNIB_LSB      0
`define DOD_BYTE_MSB        7
`define DOD_BYTE_LSB        0
`define DOD_CS_MSB          9
`define DOD_CS_LSB          8
`define DOD_STATE_MSB       7
`define DOD_STATE_LSB       4

// ***************************************************************
// Cycle and word counts
// ***************************************************************
`define DOD_CYC_ONE         3'h1
`define DOD_CYC_TWO         3'h2
`define DOD_CYC_THREE       3'h3
`define DOD_CYC_FOUR        3'h4
`define DOD_WORDS_ONE       2'h1
`define DOD_WORDS_TWO       2'h2

// ***************************************************************
// Condition selector codes
// ***************************************************************
`define DOD_CS_EXT_LOW      2'h0
`define DOD_CS_TEST_SET     2'h1
`define DOD_CS_TEST_CLR     2'h2
`define DOD_CS_NONE         2'h3

// ***************************************************************
// Reset values
// ***************************************************************
`define DOD_RST_WORD        16'h0000
`define DOD_RST_BYTE        8'h00
`define DOD_RST_NIB         4'h0

`endif

/* testbench.sv */
// Self-checking bench for the opcode decoder
`timescale 1ns/10ps
module testbench;
    logic        clock_i;
    logic        sys_rst_i;
    logic [6:0]  flg;
    logic [3:0]  nib [7] = '{4'h4, 4'h0, 4'he, 4'h2, 4'h6, 4'ha, 4'hc};
    int          errors = 0;
    int          cmp_count = 0;
    int          cyc_q = 0;
    wire         fetch_valid_i, second_pending_o, dec_valid_o, operand_is_addr_o;
    wire         branch_taken_o, mmr_hazard_o, unknown_o;
    wire [15:0]  fetch_word_i, long_word_o;
    wire [5:0]   op_class_o;
    wire [1:0]   words_o, cond_selector_o;
    wire [2:0]   cycles_o;
    wire [3:0]   shift_count_field_o, low_nibble_o;
    wire [7:0]   operand_byte_o;
    // ***************************************************************
    // Instances and clock
    // ***************************************************************
    dod_fetch dod_fetch_i (.clock_i, .fetch_valid_o(fetch_valid_i), .fetch_word_o(fetch_word_i));
    dod_decoder dod_decoder_i (.clock_i, .sys_rst_i, .fetch_valid_i, .fetch_word_i,
        .accum_zero_i(flg[6]), .accum_neg_i(flg[5]), .overflow_i(flg[4]), .carry_i(flg[3]),
        .test_flag_i(flg[2]), .aux_nonzero_i(flg[1]), .ext_status_input_i(flg[0]),
        .second_pending_o, .dec_valid_o, .op_class_o, .words_o, .cycles_o, .shift_count_field_o,
        .operand_byte_o, .operand_is_addr_o, .long_word_o, .branch_taken_o, .cond_selector_o,
        .low_nibble_o, .mmr_hazard_o, .unknown_o);
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            errors++;
        end
    endtask
    // Zero second word means a one-word instruction; flags are {z,l,v,c,test,aux,ext}
    task automatic chk(input logic [15:0] w1, input logic [5:0] cls, input logic [2:0] cyc,
                       input logic [15:0] w2 = 16'h0, input logic [6:0] f = 7'h01);
        flg = f;
        dod_fetch_i.gap(2);
        dod_fetch_i.put(w1);
        if (w2 != 16'h0)
            dod_fetch_i.put(w2);
        cmp("dec_valid", 16'h1, dec_valid_o);
        cmp("op_class", cls, op_class_o);
        cmp("words", (w2 != 16'h0) ? 16'h2 : 16'h1, words_o);
        cmp("cycles", cyc, cycles_o);
    endtask
    // ***************************************************************
    // Timeout and main sequence
    // ***************************************************************
    always @(posedge clock_i)
    begin
        cyc_q <= cyc_q + 1;
        if (cyc_q == 3000)
        begin
            errors++;
            results();
        end
    end
    initial
    begin
        sys_rst_i = 1'b1;
        flg       = 7'h01;
        repeat (2) @(posedge clock_i);
        #1;
        sys_rst_i = 1'b0;
        cmp("cond_selector", 16'h3, cond_selector_o);
        chk(16'hbe00, 6'h01, 1);
        chk(16'h2a55, 6'h02, 1);
        cmp("shift", 16'ha, shift_count_field_o);
        cmp("operand", 16'h55, operand_byte_o);
        cmp("operand_is_addr", 16'h1, operand_is_addr_o);
        chk(16'h6112, 6'h03, 1);
        chk(16'hb8ff, 6'h04, 1);
        chk(16'hbf93, 6'h05, 2, 16'h1234);
        chk(16'h6000, 6'h06, 1);
        chk(16'h6200, 6'h07, 1);
        chk(16'h6300, 6'h08, 1);
        chk(16'h7810, 6'h09, 1);
        chk(16'h6e00, 6'h0a, 1);
        chk(16'hbfb1, 6'h0b, 2, 16'hff00);
        chk(16'hbe81, 6'h0c, 2, 16'h00ff);
        chk(16'hbe04, 6'h0d, 1);
        $display("test arithmetic group done");
        chk(16'hbe20, 6'h0e, 4);
        chk(16'h7900, 6'h0f, 4, 16'h0040);
        chk(16'h7b00, 6'h10, 4, 16'h0041, 7'h03);
        chk(16'h7b00, 6'h10, 2, 16'h0041);
        cmp("branch_taken", 16'h0, branch_taken_o);
        chk(16'he100, 6'h11, 4, 16'h0042, 7'h05);
        cmp("cond_selector", 16'h1, cond_selector_o);
        chk(16'he100, 6'h11, 2, 16'h0042);
        chk(16'he311, 6'h11, 4, 16'h0043, 7'h09);
        chk(16'he38c, 6'h11, 4, 16'h0044, 7'h41);
        chk(16'he38c, 6'h11, 2, 16'h0044, 7'h21);
        chk(16'he000, 6'h11, 4, 16'h0045, 7'h00);
        chk(16'he000, 6'h11, 3, 16'h0045);
        chk(16'hea00, 6'h12, 4, 16'h0046);
        chk(16'heb00, 6'h12, 4, 16'h0047, 7'h05);
        chk(16'hbe30, 6'h18, 4);
        chk(16'h7a00, 6'h19, 4, 16'h0300);
        $display("test branch group done");
        chk(16'h4300, 6'h13, 1);
        chk(16'h6f00, 6'h14, 1);
        chk(16'ha800, 6'h15, 3, 16'h0001);
        cmp("mmr_hazard", 16'h1, mmr_hazard_o);
        chk(16'ha900, 6'h16, 3, 16'h0100);
        cmp("mmr_hazard", 16'h0, mmr_hazard_o);
        chk(16'ha500, 6'h17, 3, 16'h0200);
        foreach (nib[i]) chk({12'hbe4, nib[i]}, 6'h1a, 1);
        chk(16'hbe48, 6'h00, 1);
        cmp("unknown", 16'h1, unknown_o);
        cmp("low_nibble", 16'h8, low_nibble_o);
        chk(16'hbe01, 6'h1b, 1);
        for (int i = 0; i < 4; i++) chk(16'hbf44 + 16'(i), 6'h1c, 1);
        chk(16'h7700, 6'h1d, 1);
        chk(16'hbe22, 6'h1e, 1);
        chk(16'haf12, 6'h1f, 2, 16'h8000);
        cmp("long_word", 16'h8000, long_word_o);
        chk(16'h1300, 6'h20, 1);
        chk(16'hbf85, 6'h21, 2, 16'h0f0f);
        chk(16'h6a00, 6'h22, 1);
        dod_fetch_i.put(16'hbe04);
        cmp("op_class", 16'h0d, op_class_o);
        dod_fetch_i.put(16'hbe01);
        cmp("op_class", 16'h1b, op_class_o);
        $display("test data group done");
        results();
    end
endmodule
bind dod_decoder dod_decoder_properties dod_decoder_properties_i (.*);
